// [dcc_chan_if.sv]
// Carrier between the register/arbiter top and one channel engine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface dcc_chan_if;
    logic        ctrl_we;
    logic        addr_we;
    logic        count_we;
    logic [31:0] wdata;
    logic        req;
    logic        grant;
    logic        done;
    logic [7:0]  ctrl;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] count;
    logic        want;
    logic        unit_done;
    logic        complete;

    modport chan (
        input  ctrl_we, addr_we, count_we, wdata, req, grant, done,
        output ctrl, src, dst, count, want, unit_done, complete
    );
    modport top (
        output ctrl_we, addr_we, count_we, wdata, req, grant, done,
        input  ctrl, src, dst, count, want, unit_done, complete
    );
endinterface

// [dcc_channel.sv]
// One DMA channel: control register, request flag, address stepping.
// Assumes grant only while want is high and done only after a grant.
`timescale 1ns/10ps
module dcc_channel (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    dcc_chan_if.chan ch
);
    typedef struct packed {
        logic [7:0]        ctrl;
        logic [15:0]       src;
        logic [15:0]       dst;
        logic [15:0]       start_src;
        logic [15:0]       start_dst;
        logic [15:0]       count;
        logic [4:0]        ring;
        dcc_pkg::dcc_state_t st;
        logic              unit_done;
        logic              complete;
    } dcc_chan_state_t;

    dcc_chan_state_t s;
    dcc_chan_state_t next_s;
    logic [15:0]     step;

    always_comb
    begin
        next_s = s;
        next_s.unit_done = 1'b0;
        next_s.complete = 1'b0;
        step = s.ctrl[dcc_pkg::SIZE_BIT] ? dcc_pkg::STEP_BYTE
                                          : dcc_pkg::STEP_HALF; // see RULE12
        if (ch.ctrl_we)
        begin
            // A one written to the flag keeps the old value.
            next_s.ctrl = {ch.wdata[7:2],
                           s.ctrl[dcc_pkg::FLAG_BIT] & ch.wdata[1],
                           ch.wdata[0]}; // see RULE6
        end
        if (ch.addr_we)
        begin
            next_s.src = ch.wdata[15:0];
            next_s.dst = ch.wdata[31:16];
            next_s.start_src = ch.wdata[15:0];
            next_s.start_dst = ch.wdata[31:16];
        end
        if (ch.count_we)
        begin
            next_s.count = ch.wdata[15:0];
            next_s.ring = 5'h00;
        end
        case (s.st)
            dcc_pkg::ST_IDLE:
            begin
                // A request while the flag stands is dropped.
                if (ch.req && !s.ctrl[dcc_pkg::FLAG_BIT]) // see RULE7
                begin
                    next_s.ctrl[dcc_pkg::FLAG_BIT] = 1'b1; // see RULE5
                    next_s.st = dcc_pkg::ST_WAIT;
                end
            end
            dcc_pkg::ST_WAIT:
            begin
                // The top has already committed the port on a grant, so a
                // flag clear in the same cycle must not orphan the unit.
                if (ch.grant) // see RULE11
                    next_s.st = dcc_pkg::ST_RUN;
                else if (!next_s.ctrl[dcc_pkg::FLAG_BIT])
                    next_s.st = dcc_pkg::ST_IDLE;
            end
            dcc_pkg::ST_RUN:
            begin
                // Enable is not looked at here, so an accepted unit ends.
                if (ch.done) // see RULE11
                begin
                    next_s.st = dcc_pkg::ST_IDLE;
                    next_s.ctrl[dcc_pkg::FLAG_BIT] = 1'b0;
                    next_s.unit_done = 1'b1; // see RULE17
                    if (s.ctrl[dcc_pkg::SSTEP_BIT]) // see RULE13
                        next_s.src = s.src + step; // see RULE16
                    if (s.ctrl[dcc_pkg::DSTEP_BIT]) // see RULE14
                        next_s.dst = s.dst + step;
                    next_s.count = s.count - 16'h0001;
                    if (s.ctrl[dcc_pkg::MODE_BIT]) // see RULE1
                    begin
                        // Counter free-runs; no completion event.
                        next_s.ring = s.ring + 5'h01; // see RULE3
                        if (s.ring == dcc_pkg::RING_LAST) // see RULE2
                        begin
                            next_s.src = s.start_src;
                            next_s.dst = s.start_dst;
                        end
                    end
                    else if (s.count == 16'h0000)
                    begin
                        next_s.complete = 1'b1; // see RULE4
                        next_s.ctrl[dcc_pkg::EN_BIT] = 1'b0;
                    end
                end
            end
            default:
                next_s.st = dcc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.ctrl <= dcc_pkg::CTRL_RESET;
            s.st <= dcc_pkg::ST_IDLE;
        end
        else if (ce)
            s <= next_s;
    end

    assign ch.ctrl = s.ctrl;
    assign ch.src = s.src;
    assign ch.dst = s.dst;
    assign ch.count = s.count;
    assign ch.unit_done = s.unit_done;
    assign ch.complete = s.complete;
    assign ch.want = (s.st == dcc_pkg::ST_WAIT)
                     && s.ctrl[dcc_pkg::FLAG_BIT]
                     && s.ctrl[dcc_pkg::EN_BIT]; // see RULE11
endmodule

// [dcc_engine_model.sv]
// Behavioural transfer engine on the far side of the transfer port.
// Assumes one unit in flight; each unit is answered lat + 1 cycles after its request rises.
`timescale 1ns/10ps
module dcc_engine_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       req,
    input  wire logic [3:0] lat,
    output logic            done
);
    logic [3:0] cnt;
    logic       busy;

    // Once answered it stays silent until the request drops, so a
    // request that falls late is never answered twice.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            done <= 1'b0;
            cnt  <= 4'h0;
            busy <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (req && !busy)
            begin
                if (cnt >= lat)
                begin
                    done <= 1'b1;
                    busy <= 1'b1;
                    cnt  <= 4'h0;
                end
                else
                    cnt <= cnt + 4'h1;
            end
            if (!req)
                busy <= 1'b0;
        end
    end
endmodule

// [dcc_pkg.sv]
// Constants shared by the DMA channel 7..9 control block.
// Assumes a 32-bit classic Wishbone register bus, byte addressed.
package dcc_pkg;

    localparam int unsigned NCH = 3;

    // Register byte addresses.
    localparam logic [31:0] CH7_CTRL_ADR = 32'h0080_0448;
    localparam logic [31:0] CH8_CTRL_ADR = 32'h0080_0458;
    localparam logic [31:0] CH9_CTRL_ADR = 32'h0080_0468;
    localparam logic [31:0] SWREQ_ADR    = 32'h0080_0480;
    localparam logic [31:0] ISTAT_ADR    = 32'h0080_0484;
    localparam logic [31:0] IMASK_ADR    = 32'h0080_0488;
    localparam logic [31:0] ADDR_BASE    = 32'h0080_04A0;
    localparam logic [31:0] COUNT_BASE   = 32'h0080_04B0;
    localparam logic [31:0] ADR_STRIDE   = 32'h0000_0004;

    // Control register field positions and reset value.
    localparam int unsigned MODE_BIT  = 0;
    localparam int unsigned FLAG_BIT  = 1;
    localparam int unsigned SRC_LSB   = 2;
    localparam int unsigned EN_BIT    = 4;
    localparam int unsigned SIZE_BIT  = 5;
    localparam int unsigned SSTEP_BIT = 6;
    localparam int unsigned DSTEP_BIT = 7;
    localparam logic [7:0]  CTRL_RESET = 8'h00;

    // Request source codes.
    localparam logic [1:0] SRC_SW    = 2'h0;
    localparam logic [1:0] SRC_PERIPH = 2'h1;
    localparam logic [1:0] SRC_CHAIN = 2'h3;

    // Ring length in units and address steps.
    localparam int unsigned RING_UNITS = 32;
    localparam logic [4:0]  RING_LAST  = 5'(RING_UNITS - 1);
    localparam logic [15:0] STEP_BYTE  = 16'h0001;
    localparam logic [15:0] STEP_HALF  = 16'h0002;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } dcc_state_t;

endpackage

// [dcc_top.sv]
// DMA channels 7, 8 and 9: Wishbone registers, request sources,
// arbitration onto one transfer port, and the completion interrupt.
// Assumes a transfer engine outside that answers XFER_REQ with one
// XFER_DONE pulse per unit.
//
// Overview of operation
// RULE1: control bit 0 picks normal mode (0) or ring-buffer mode (1).
// RULE2: ring mode returns to the start addresses after 32 units.
// RULE3: ring mode counter free-runs until software clears enable.
// RULE4: ring mode never raises the completion interrupt.
// RULE5: a request sets the readable request flag at bit 1.
// RULE6: writing 0 clears the flag; writing 1 leaves it unchanged.
// RULE7: requests arriving while the flag is set are not accepted.
// RULE8: channel 7 sources: software, serial 2 empty, none, channel 6 unit.
// RULE9: channel 8 sources: software, timer event bus 0; others unused.
// RULE10: channel 9 sources: software or channel 8 unit; others unused.
// RULE11: bit 4 enables transfers; an accepted unit still completes.
// RULE12: bit 5 selects 16-bit (0) or 8-bit (1) units.
// RULE13: bit 6 makes the source address step, else it stays fixed.
// RULE14: bit 7 makes the destination address step, else it stays fixed.
// RULE15: with source code 00 any software request write starts a request (here only a write that selects the channel's own byte lane).
// RULE16: stepping adds 1 per byte unit and 2 per halfword unit.
// RULE17: each channel pulses unit done for one cycle after every unit.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
module dcc_top (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic [31:0] WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic        WB_WE_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    output wire logic [31:0] WB_DAT_O,
    output wire logic        WB_ACK_O,
    input  wire logic        SER2_TX_EMPTY,
    input  wire logic        TIMER_EVT0,
    input  wire logic        CH6_UNIT_DONE,
    output wire logic        XFER_REQ,
    output wire logic [1:0]  XFER_CHAN,
    output wire logic [15:0] XFER_SRC,
    output wire logic [15:0] XFER_DST,
    output wire logic        XFER_BYTE,
    input  wire logic        XFER_DONE,
    output wire logic [2:0]  UNIT_DONE,
    output wire logic        IRQ
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [2:0]  istat;
        logic [2:0]  imask;
        logic        busy;
        logic [1:0]  owner;
        logic [15:0] xsrc;
        logic [15:0] xdst;
        logic        xbyte;
    } dcc_top_state_t;

    dcc_top_state_t s;
    dcc_top_state_t next_s;

    dcc_chan_if cif[dcc_pkg::NCH] ();

    logic [7:0]  ctrl_v   [dcc_pkg::NCH];
    logic [15:0] src_v    [dcc_pkg::NCH];
    logic [15:0] dst_v    [dcc_pkg::NCH];
    logic [15:0] count_v  [dcc_pkg::NCH];
    logic [2:0]  want_v;
    logic [2:0]  unit_v;
    logic [2:0]  cmpl_v;
    logic [2:0]  ctrl_we;
    logic [2:0]  addr_we;
    logic [2:0]  count_we;
    logic [2:0]  req_v;
    logic [2:0]  grant_v;
    logic [2:0]  done_v;
    logic [2:0]  sw_req;
    logic        hit;
    logic        wr;
    logic [1:0]  sel7;
    logic [1:0]  sel8;
    logic [1:0]  sel9;

    genvar gi;
    generate
        for (gi = 0; gi < dcc_pkg::NCH; gi++)
        begin : g_ch
            dcc_channel u_chan (
                .clk (CLK),
                .rst (RST),
                .ce  (CE),
                .ch  (cif[gi])
            );
            assign cif[gi].ctrl_we  = ctrl_we[gi];
            assign cif[gi].addr_we  = addr_we[gi];
            assign cif[gi].count_we = count_we[gi];
            assign cif[gi].wdata    = WB_DAT_I;
            assign cif[gi].req      = req_v[gi];
            assign cif[gi].grant    = grant_v[gi];
            assign cif[gi].done     = done_v[gi];
            assign ctrl_v[gi]  = cif[gi].ctrl;
            assign src_v[gi]   = cif[gi].src;
            assign dst_v[gi]   = cif[gi].dst;
            assign count_v[gi] = cif[gi].count;
            assign want_v[gi]  = cif[gi].want;
            assign unit_v[gi]  = cif[gi].unit_done;
            assign cmpl_v[gi]  = cif[gi].complete;
            // Only a write that selects this channel's own byte lane counts.
            assign sw_req[gi] = wr && (WB_ADR_I == dcc_pkg::SWREQ_ADR)
                                && WB_SEL_I[gi]; // see RULE15
            assign addr_we[gi] = wr && (WB_SEL_I == 4'hF) && (WB_ADR_I
                == dcc_pkg::ADDR_BASE + dcc_pkg::ADR_STRIDE * 32'(gi));
            assign count_we[gi] = wr && (WB_SEL_I[1:0] == 2'h3)
                && (WB_ADR_I == dcc_pkg::COUNT_BASE
                    + dcc_pkg::ADR_STRIDE * 32'(gi));
        end
    endgenerate

    // Writes land on the edge where the master samples ack.
    assign hit = WB_CYC_I && WB_STB_I;
    assign wr  = hit && WB_WE_I && s.ack;

    assign ctrl_we[0] = wr && WB_SEL_I[0]
                        && (WB_ADR_I == dcc_pkg::CH7_CTRL_ADR);
    assign ctrl_we[1] = wr && WB_SEL_I[0]
                        && (WB_ADR_I == dcc_pkg::CH8_CTRL_ADR);
    assign ctrl_we[2] = wr && WB_SEL_I[0]
                        && (WB_ADR_I == dcc_pkg::CH9_CTRL_ADR);

    assign sel7 = ctrl_v[0][dcc_pkg::SRC_LSB +: 2];
    assign sel8 = ctrl_v[1][dcc_pkg::SRC_LSB +: 2];
    assign sel9 = ctrl_v[2][dcc_pkg::SRC_LSB +: 2];

    // Prohibited codes select no source at all.
    always_comb
    begin
        req_v = 3'h0;
        case (sel7) // see RULE8
            dcc_pkg::SRC_SW:     req_v[0] = sw_req[0];
            dcc_pkg::SRC_PERIPH: req_v[0] = SER2_TX_EMPTY;
            dcc_pkg::SRC_CHAIN:  req_v[0] = CH6_UNIT_DONE;
            default:             req_v[0] = 1'b0;
        endcase
        case (sel8) // see RULE9
            dcc_pkg::SRC_SW:     req_v[1] = sw_req[1];
            dcc_pkg::SRC_PERIPH: req_v[1] = TIMER_EVT0;
            default:             req_v[1] = 1'b0;
        endcase
        case (sel9) // see RULE10
            dcc_pkg::SRC_SW:     req_v[2] = sw_req[2];
            dcc_pkg::SRC_CHAIN:  req_v[2] = unit_v[1];
            default:             req_v[2] = 1'b0;
        endcase
    end

    always_comb
    begin
        next_s = s;
        grant_v = 3'h0;
        done_v = 3'h0;

        // One-cycle ack; read data is captured together with it.
        next_s.ack = hit && !s.ack;
        next_s.rdata = 32'h0000_0000;
        if (hit && !s.ack && !WB_WE_I)
        begin
            if (WB_ADR_I == dcc_pkg::CH7_CTRL_ADR)
                next_s.rdata = {24'h00_0000, ctrl_v[0]}; // see RULE5
            else if (WB_ADR_I == dcc_pkg::CH8_CTRL_ADR)
                next_s.rdata = {24'h00_0000, ctrl_v[1]};
            else if (WB_ADR_I == dcc_pkg::CH9_CTRL_ADR)
                next_s.rdata = {24'h00_0000, ctrl_v[2]};
            else if (WB_ADR_I == dcc_pkg::ISTAT_ADR)
                next_s.rdata = {29'h0000_0000, s.istat};
            else if (WB_ADR_I == dcc_pkg::IMASK_ADR)
                next_s.rdata = {29'h0000_0000, s.imask};
            else
            begin
                for (int i = 0; i < dcc_pkg::NCH; i++)
                begin
                    if (WB_ADR_I == dcc_pkg::ADDR_BASE
                        + dcc_pkg::ADR_STRIDE * 32'(i))
                        next_s.rdata = {dst_v[i], src_v[i]};
                    if (WB_ADR_I == dcc_pkg::COUNT_BASE
                        + dcc_pkg::ADR_STRIDE * 32'(i))
                        next_s.rdata = {16'h0000, count_v[i]};
                end
            end
        end

        // Set wins over a write-one clear in the same cycle.
        next_s.istat = s.istat;
        if (wr && WB_SEL_I[0] && (WB_ADR_I == dcc_pkg::ISTAT_ADR))
            next_s.istat = s.istat & ~WB_DAT_I[2:0];
        next_s.istat = next_s.istat | cmpl_v;
        if (wr && WB_SEL_I[0] && (WB_ADR_I == dcc_pkg::IMASK_ADR))
            next_s.imask = WB_DAT_I[2:0];

        // Fixed priority: channel 7 first, then 8, then 9.
        if (!s.busy)
        begin
            for (int i = dcc_pkg::NCH - 1; i >= 0; i--)
            begin
                if (want_v[i])
                begin
                    grant_v = 3'h0;
                    grant_v[i] = 1'b1;
                    next_s.owner = 2'(i);
                    next_s.xsrc = src_v[i];
                    next_s.xdst = dst_v[i];
                    next_s.xbyte = ctrl_v[i][dcc_pkg::SIZE_BIT];
                end
            end
            next_s.busy = |want_v;
        end
        else if (XFER_DONE)
        begin
            done_v[s.owner] = 1'b1;
            next_s.busy = 1'b0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            s <= '0;
        else if (CE)
            s <= next_s;
    end

    // While CE is low all registered state holds, so ack and the transfer port keep their values.
    assign WB_ACK_O  = s.ack;
    assign WB_DAT_O  = s.rdata;
    assign XFER_REQ  = s.busy;
    assign XFER_CHAN = s.owner;
    assign XFER_SRC  = s.xsrc;
    assign XFER_DST  = s.xdst;
    assign XFER_BYTE = s.xbyte;
    assign UNIT_DONE = unit_v;
    assign IRQ       = |(s.istat & s.imask);
endmodule

// [dcc_top_asserts.sv]
// Concurrent checks on the ports of dcc_top, attached by bind.
// Assumes one clock and the synchronous reset RST.
`timescale 1ns/10ps
module dcc_top_asserts (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        CE,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        XFER_REQ,
    input wire logic [1:0]  XFER_CHAN,
    input wire logic [15:0] XFER_SRC,
    input wire logic [15:0] XFER_DST,
    input wire logic        XFER_BYTE,
    input wire logic        XFER_DONE,
    input wire logic [2:0]  UNIT_DONE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_ack_follows: assert property (
        WB_CYC_I && WB_STB_I && !WB_ACK_O && CE |=> WB_ACK_O)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (
        WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
    a_dat_quiet: assert property (
        !WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data without ack");
    a_xfer_holds: assert property (
        XFER_REQ && !XFER_DONE |=> XFER_REQ && $stable(XFER_CHAN)
        && $stable(XFER_SRC) && $stable(XFER_DST) && $stable(XFER_BYTE))
        else $error("transfer request changed before done");
    a_xfer_ends: assert property (
        XFER_REQ && XFER_DONE && CE |=> !XFER_REQ)
        else $error("transfer request not released");
    a_unit_pulse: assert property (
        XFER_REQ && XFER_DONE && CE |=>
        UNIT_DONE == 3'(3'h1 << $past(XFER_CHAN)))
        else $error("unit pulse missing or on wrong channel");
    a_unit_cause: assert property (
        UNIT_DONE != 3'h0 |-> $past(XFER_REQ && XFER_DONE)
        && $onehot(UNIT_DONE)) else $error("unit pulse without a unit");
    a_chan_legal: assert property (
        XFER_REQ |-> XFER_CHAN != 2'h3) else $error("no such channel");
endmodule

bind dcc_top dcc_top_asserts u_chk (
    .CLK(CLK), .RST(RST), .CE(CE), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .XFER_REQ(XFER_REQ), .XFER_CHAN(XFER_CHAN), .XFER_SRC(XFER_SRC),
    .XFER_DST(XFER_DST), .XFER_BYTE(XFER_BYTE), .XFER_DONE(XFER_DONE),
    .UNIT_DONE(UNIT_DONE)
);

// [dcc_top_tb.sv]
// Self-checking bench for dcc_top: register tests and DMA runs.
// Assumes dcc_engine_model answers the transfer port.
`timescale 1ns/10ps
module dcc_top_tb;
    localparam logic [31:0] C7 = dcc_pkg::CH7_CTRL_ADR;
    localparam logic [31:0] C8 = dcc_pkg::CH8_CTRL_ADR;
    localparam logic [31:0] C9 = dcc_pkg::CH9_CTRL_ADR;
    localparam logic [31:0] SWR = dcc_pkg::SWREQ_ADR;
    localparam logic [31:0] IST = dcc_pkg::ISTAT_ADR;
    localparam logic [31:0] AB = dcc_pkg::ADDR_BASE;
    localparam logic [31:0] CB = dcc_pkg::COUNT_BASE;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic        we = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        ser = 1'b0;
    logic        tmr = 1'b0;
    logic        ch6 = 1'b0;
    logic [3:0]  lat = 4'h1;
    logic [31:0] rdat;
    logic [31:0] got;
    logic        ack;
    logic        xreq;
    logic        xdone;
    logic        irq;
    logic [2:0]  udone;
    logic [1:0]  xchan;
    logic [15:0] xsrc;
    logic [15:0] xdst;
    logic        xbyte;
    logic [34:0] xlast;
    int          units [3] = '{0, 0, 0};
    int          failures = 0;
    int          compares = 0;
    int          n;

    dcc_top uut (.CLK(clk), .RST(rst), .CE(1'b1), .WB_ADR_I(adr),
        .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .SER2_TX_EMPTY(ser), .TIMER_EVT0(tmr), .CH6_UNIT_DONE(ch6),
        .XFER_REQ(xreq), .XFER_CHAN(xchan), .XFER_SRC(xsrc),
        .XFER_DST(xdst), .XFER_BYTE(xbyte), .XFER_DONE(xdone),
        .UNIT_DONE(udone), .IRQ(irq));
    dcc_engine_model eng (.clk(clk), .rst(rst), .req(xreq), .lat(lat),
        .done(xdone));

    always #20 clk = ~clk;
    always @(posedge clk)
        for (int i = 0; i < 3; i++)
            units[i] <= units[i] + int'(udone[i] === 1'b1);
    // Remembers what the last granted unit put on the transfer port.
    always @(posedge clk)
        if (xreq === 1'b1)
            xlast <= {xchan, xbyte, xdst, xsrc};

    task automatic end_of_test;
        $display("Compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    // Classic single cycle: hold everything until ack is sampled.
    task automatic wb(input logic w, input logic [31:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, s};
        @(posedge clk);
        while (ack !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        got = rdat;
        {cyc, stb, we} <= 3'h0;
        if (k >= 20)
            chk(32'h0, 32'h1);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        wb(1'b1, a, d, s);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hF);
        chk(got, e);
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task automatic wait_units(input int ch, input int t);
        int k;
        k = 0;
        while (units[ch] < t && k < 2000)
        begin
            @(posedge clk);
            k++;
        end
        chk(32'(units[ch] >= t), 32'h1);
    endtask

    initial
    begin
        #2400000;
        chk(32'h0, 32'h1);
        end_of_test;
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(C7, 32'h0);
        rd(C8, 32'h0);
        rd(C9, 32'h0);
        rd(32'h0080_0490, 32'h0);
        wr(C7, 32'h02, 4'h1);
        rd(C7, 32'h00);
        wr(SWR, 32'h0, 4'h1);
        rd(C7, 32'h02);
        wr(C7, 32'h02, 4'h1);
        rd(C7, 32'h02);
        wr(C7, 32'h00, 4'h1);
        rd(C7, 32'h00);
        ser <= 1'b1;
        tmr <= 1'b1;
        wr(C7, 32'h08, 4'h1);
        rd(C7, 32'h08);
        for (int c = 1; c < 3; c++)
        begin
            wr(C8, 32'(c + 1) << 2, 4'h1);
            rd(C8, 32'(c + 1) << 2);
            wr(C9, 32'(c) << 2, 4'h1);
            rd(C9, 32'(c) << 2);
        end
        tmr <= 1'b0;
        wr(C7, 32'h04, 4'h1);
        rd(C7, 32'h06);
        ser <= 1'b0;
        wr(C7, 32'h00, 4'h1);
        wr(C8, 32'h00, 4'h1);
        wr(C9, 32'h00, 4'h1);
        // Byte units, source stepping, destination fixed, count 1.
        wr(AB, 32'h2000_1000, 4'hF);
        wr(CB, 32'h1, 4'h3);
        wr(C7, 32'h70, 4'h1);
        lat <= 4'h5;
        wr(SWR, 32'h0, 4'h1);
        wr(SWR, 32'h0, 4'h1);
        wait_units(0, 1);
        repeat (20) @(posedge clk);
        chk(units[0], 32'h1);
        rd(C7, 32'h70);
        wr(SWR, 32'h0, 4'h1);
        wait_units(0, 2);
        repeat (3) @(posedge clk);
        rd(C7, 32'h60);
        rd(AB, 32'h2000_1002);
        chk({29'h0, xlast[34:32]}, 32'h1);
        chk(xlast[31:0], 32'h2000_1001);
        rd(IST, 32'h1);
        irq_is(1'b0);
        wr(dcc_pkg::IMASK_ADR, 32'h7, 4'hF);
        irq_is(1'b1);
        wr(IST, 32'h1, 4'hF);
        irq_is(1'b0);
        // Ring of halfword units on ch8, ch9 chained behind it.
        wr(AB + 32'h4, 32'h4000_3000, 4'hF);
        wr(CB + 32'h4, 32'h5, 4'h3);
        wr(CB + 32'h8, 32'h100, 4'h3);
        wr(C9, 32'h1C, 4'h1);
        wr(C8, 32'h55, 4'h1);
        lat <= 4'h1;
        tmr <= 1'b1;
        wait_units(1, 32);
        tmr <= 1'b0;
        repeat (30) @(posedge clk);
        rd(C8, 32'h55);
        n = units[1];
        rd(AB + 32'h4, {16'h4000, 16'h3000 + 16'(2 * (n % 32))});
        chk(32'(units[2] != 0), 32'h1);
        rd(IST, 32'h0);
        n = units[0];
        // Chained halfword unit with destination stepping; enable is
        // cleared while the slow unit runs, which must still finish.
        wr(C7, 32'h9C, 4'h1);
        lat <= 4'hF;
        ch6 <= 1'b1;
        @(posedge clk);
        ch6 <= 1'b0;
        wr(C7, 32'h8C, 4'h1);
        wait_units(0, n + 1);
        rd(C7, 32'h8C);
        rd(AB, 32'h2002_1002);
        chk({29'h0, xlast[34:32]}, 32'h0);
        chk(xlast[31:0], 32'h2000_1002);
        end_of_test;
    end
endmodule
